// *** tb/asb_modem.sv ***
// Modem model: carrier and data-set-ready levels, idle receive line, 16x clock.
// Assumes the bench moves the modem lines through set_lines just after an edge.
`timescale 1ns/1ps
module asb_modem (
    input wire logic aclk,
    output logic rxd,
    output logic cts_n,
    output logic dcd,
    output logic dsr,
    output logic ext_clk
);
    initial
    begin
        rxd = 1'h1;
        cts_n = 1'h0;
        dcd = 1'h1;
        dsr = 1'h1;
        ext_clk = 1'h0;
    end
    always @(posedge aclk)
        ext_clk <= ~ext_clk;
    task set_lines(input logic c, input logic s);
        dcd <= c;
        dsr <= s;
    endtask : set_lines
    task set_cts(input logic v);
        cts_n <= v;
    endtask : set_cts
    // Sends a frame LSB first, b cycles a bit; the line stays at the last bit
    task send(input logic [7:0] f, input int b);
        for (int j = 0; j < 8; j++)
        begin
            rxd <= f[j];
            repeat (b) @(posedge aclk);
        end
    endtask : send
endmodule : asb_modem

// *** tb/testbench.sv ***
// Self-checking bench: modem lines, interrupt latch and bit timing.
// Assumes asb_top with AXI4-Lite registers and the modem model beside it.
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00, f;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [3:0] ws = 4'hF;
    logic [1:0] rresp, r, bresp, b;
    logic awr, wrd, bv, arr, rv, rxd, txd, cts_n, dcd, dsr, eck, irq, cc, po, oe;
    int err_count = 0, n_tests = 0, seed = 63486, c, k, i;
    int divs[3] = '{192, 96, 32};
    logic [7:0] codes[3] = '{8'h1E, 8'h0F, 8'h00};
    asb_top asb_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .rxd(rxd), .txd(txd), .cts_n(cts_n), .dcd(dcd), .dsr(dsr), .receive_clock_pin_i(eck),
        .receive_clock_pin_o(po), .receive_clock_pin_oe(oe), .irq(irq));
    asb_modem asb_modem_i (.aclk(aclk), .rxd(rxd), .cts_n(cts_n), .dcd(dcd), .dsr(dsr),
        .ext_clk(eck));
    initial
        forever #20 aclk = ~aclk;
    // Each bus task ends one edge late so no strobe is driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awa <= a;
        wd <= {24'h0, v};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
        end
        while (!bv);
        b = bresp;
        bry <= 1'h0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'h1;
        rry <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
        end
        while (!rv);
        d = rdat;
        r = rresp;
        rry <= 1'h0;
        @(posedge aclk);
    endtask : rd
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task wt;
        repeat (3) @(posedge aclk);
    endtask : wt
    initial
    begin
        repeat (40000) @(posedge aclk);
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h08);
        chk("command", 32'h0, d);
        rd(8'h44);
        chk("bad resp", 32'h2, r);
        wr(8'h44, 8'h00);
        chk("bad wresp", 32'h2, b);
        for (k = 0; k < 4; k++)
        begin
            c = $random(seed);
            asb_modem_i.set_lines(c[0], c[1]);
            wt();
            rd(8'h04);
            chk("modem bits", c[1:0], d[6:5]);
            chk("irq off", 32'h0, irq);
        end
        $display("done disabled");
        cc = c[0];
        wr(8'h08, 8'h01);
        chk("write resp", 32'h0, b);
        asb_modem_i.set_lines(!cc, c[1]);
        wt();
        chk("irq set", 32'h1, irq);
        asb_modem_i.set_lines(cc, c[1]);
        wt();
        rd(8'h04);
        chk("latched", !cc, d[5]);
        chk("irq bit", 32'h1, d[7]);
        wt();
        chk("reirq", 32'h1, irq);
        rd(8'h04);
        chk("resampled", cc, d[5]);
        wt();
        chk("irq clear", 32'h0, irq);
        asb_modem_i.set_lines(cc, !c[1]);
        wt();
        chk("dsr irq", 32'h1, irq);
        $display("done enabled");
        for (k = 0; k < 3; k++)
        begin
            wr(8'h0C, codes[k]);
            chk("pin drive", k == 0, oe);
            cc = po;
            repeat (12) @(posedge aclk);
            if (k == 0) chk("pin clock", !cc, po);
            c = $random(seed);
            wr(8'h00, c[7:0]);
            for (i = 0; txd !== 1'h0 && i < 9000; i++) @(posedge aclk);
            repeat (divs[k] / 2) @(posedge aclk);
            for (i = 0; i < 10; i++)
            begin
                chk("txd bit", ({1'h1, c[7:0], 1'h0} >> i) & 1, txd);
                repeat (divs[k]) @(posedge aclk);
            end
        end
        $display("done baud");
        wr(8'h0C, 8'hE0);
        wr(8'h08, 8'h11);
        rd(8'h04);
        f = {2'h3, c[4:0], 1'h0};
        fork
            asb_modem_i.send(f, 32);
        join_none
        for (i = 0; i < 8; i++)
        begin
            repeat (i ? 32 : 33) @(posedge aclk);
            chk("echo", f[i], txd);
            chk("rx irq", i == 7, irq);
        end
        rd(8'h00);
        chk("rx data", c[4:0], d);
        asb_modem_i.set_cts(1'h1);
        fork
            asb_modem_i.send(f, 32);
        join_none
        repeat (33) @(posedge aclk);
        chk("echo halt", 1, txd);
        repeat (230) @(posedge aclk);
        rd(8'h00);
        chk("rx with cts", c[4:0], d);
        $display("done receive");
        wr(8'h08, 8'h0D);
        wr(8'h08, 8'h01);
        repeat (100) @(posedge aclk);
        chk("break held", 0, txd);
        repeat (200) @(posedge aclk);
        chk("break end", 1, txd);
        $display("done break");
        end_sim();
    end
endmodule : testbench

// *** verilog/asb_defines.svh ***
// Constants of the asynchronous serial adapter: offsets, fields, resets, divisors.
// Assumes an AXI4-Lite master and a bit clock derived from aclk, which acts as crystal.
`ifndef ASB_DEFINES_SVH
`define ASB_DEFINES_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define ASB_OFS_DATA 2'h0
`define ASB_OFS_STATUS 2'h1
`define ASB_OFS_COMMAND 2'h2
`define ASB_OFS_CONTROL 2'h3
`define ASB_RST_CMD 8'h00
`define ASB_RST_CTRL 8'h00
// ----------------------------------------
// Fields
// ----------------------------------------
`define ASB_CMD_EN 0
`define ASB_CMD_RXIRQ_OFF 1
`define ASB_CMD_ECHO 4
`define ASB_CMD_PAR_EN 5
`define ASB_CMD_PAR_ODD 6
`define ASB_TXC_IRQ 2'h1
`define ASB_TXC_BREAK 2'h3
`define ASB_CTRL_RXSRC 4
`define ASB_CTRL_STOP 7
`define ASB_ST_IRQ 7
// ----------------------------------------
// Divisors, counted in aclk cycles per bit of 16 ticks
// ----------------------------------------
`define ASB_DIV_1 36864
`define ASB_DIV_2 24576
`define ASB_DIV_3 16768
`define ASB_DIV_4 13696
`define ASB_DIV_5 12288
`define ASB_DIV_6 6144
`define ASB_DIV_7 3072
`define ASB_DIV_8 1536
`define ASB_DIV_9 1024
`define ASB_DIV_10 768
`define ASB_DIV_11 512
`define ASB_DIV_12 384
`define ASB_DIV_13 256
`define ASB_DIV_14 192
`define ASB_DIV_15 96
`define ASB_OVS 16
`define ASB_HALF_BIT 8
`endif

// *** verilog/asb_pkg.sv ***
// Types of the asynchronous serial adapter.
// Assumes asb_defines.svh for all numbers.
package asb_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_BRK = 2'b10,
        TX_MARK = 2'b11
    } asb_tx_st_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_DATA = 2'b01,
        RX_STOP = 2'b10
    } asb_rx_st_t;
endpackage : asb_pkg

// *** verilog/asb_top.sv ***
// Asynchronous serial adapter with AXI4-Lite registers, echo, break and baud select.
// Assumes all pins synchronous to aclk; aclk stands in for the crystal.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "asb_defines.svh"
module asb_top
    import asb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    input wire logic dcd,
    input wire logic dsr,
    input wire logic receive_clock_pin_i,
    output logic receive_clock_pin_o,
    output logic receive_clock_pin_oe,
    output logic irq
);
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic awr_ff, wr_ff, bv_ff, arr_ff, rv_ff, nxt_awr, nxt_wr, nxt_bv, nxt_arr, nxt_rv;
    logic aw_got_ff, w_got_ff, nxt_aw_got, nxt_w_got;
    logic [7:0] wa_ff, wd_ff, nxt_wa, nxt_wd;
    logic ws_ff, nxt_ws;
    logic [1:0] br_ff, rr_ff, nxt_br, nxt_rr;
    logic [7:0] rd_ff, nxt_rd;
    logic [7:0] cmd_ff, ctrl_ff, nxt_cmd, nxt_ctrl;
    logic wr_go, st_rd, dat_rd, dat_wr;
    logic [7:0] status;
    logic [7:0] rx_data_ff, nxt_rx_data;
    always_comb
    begin
        nxt_awr = awr_ff;
        nxt_wr = wr_ff;
        nxt_bv = bv_ff;
        nxt_arr = arr_ff;
        nxt_rv = rv_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_wa = wa_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_br = br_ff;
        nxt_rr = rr_ff;
        nxt_rd = rd_ff;
        nxt_cmd = cmd_ff;
        nxt_ctrl = ctrl_ff;
        st_rd = 1'b0;
        dat_rd = 1'b0;
        dat_wr = 1'b0;
        if (s_axi_awvalid && awr_ff)
        begin
            nxt_wa = s_axi_awaddr;
            nxt_aw_got = 1'b1;
            nxt_awr = 1'b0;
        end
        if (s_axi_wvalid && wr_ff)
        begin
            nxt_wd = s_axi_wdata[7:0];
            nxt_ws = s_axi_wstrb[0];
            nxt_w_got = 1'b1;
            nxt_wr = 1'b0;
        end
        wr_go = aw_got_ff && w_got_ff && !bv_ff;
        if (wr_go)
        begin
            nxt_bv = 1'b1;
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_br = (wa_ff[7:4] != 4'h0 || wa_ff[1:0] != 2'h0) ? 2'h2 : 2'h0;
            if (nxt_br == 2'h0 && ws_ff)
            begin
                unique case (wa_ff[3:2])
                    `ASB_OFS_DATA: dat_wr = 1'b1;
                    `ASB_OFS_COMMAND: nxt_cmd = wd_ff;
                    `ASB_OFS_CONTROL: nxt_ctrl = wd_ff;
                    `ASB_OFS_STATUS: nxt_cmd = cmd_ff;
                endcase
            end
        end
        if (bv_ff && s_axi_bready)
        begin
            nxt_bv = 1'b0;
            nxt_awr = 1'b1;
            nxt_wr = 1'b1;
        end
        if (s_axi_arvalid && arr_ff)
        begin
            nxt_arr = 1'b0;
            nxt_rv = 1'b1;
            nxt_rr = 2'h0;
            nxt_rd = 8'h00;
            if (s_axi_araddr[7:4] != 4'h0 || s_axi_araddr[1:0] != 2'h0)
                nxt_rr = 2'h2;
            else
            begin
                unique case (s_axi_araddr[3:2])
                    `ASB_OFS_DATA:
                    begin
                        nxt_rd = rx_data_ff;
                        dat_rd = 1'b1;
                    end
                    `ASB_OFS_STATUS:
                    begin
                        nxt_rd = status;
                        st_rd = 1'b1;
                    end
                    `ASB_OFS_COMMAND: nxt_rd = cmd_ff;
                    `ASB_OFS_CONTROL: nxt_rd = ctrl_ff;
                endcase
            end
        end
        if (rv_ff && s_axi_rready)
        begin
            nxt_rv = 1'b0;
            nxt_arr = 1'b1;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awr_ff <= 1'b1;
            wr_ff <= 1'b1;
            arr_ff <= 1'b1;
            bv_ff <= 1'b0;
            rv_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wa_ff <= 8'h00;
            wd_ff <= 8'h00;
            ws_ff <= 1'b0;
            br_ff <= 2'h0;
            rr_ff <= 2'h0;
            rd_ff <= 8'h00;
            cmd_ff <= `ASB_RST_CMD;
            ctrl_ff <= `ASB_RST_CTRL;
        end
        else
        begin
            awr_ff <= nxt_awr;
            wr_ff <= nxt_wr;
            arr_ff <= nxt_arr;
            bv_ff <= nxt_bv;
            rv_ff <= nxt_rv;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            wa_ff <= nxt_wa;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            br_ff <= nxt_br;
            rr_ff <= nxt_rr;
            rd_ff <= nxt_rd;
            cmd_ff <= nxt_cmd;
            ctrl_ff <= nxt_ctrl;
        end
    end
    assign s_axi_awready = awr_ff;
    assign s_axi_wready = wr_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;
    assign s_axi_arready = arr_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rresp = rr_ff;
    assign s_axi_rdata = {24'h000000, rd_ff};

    // ----------------------------------------
    // Frame format and baud ticks
    // ----------------------------------------
    logic en, echo, par, brk_sel;
    logic [3:0] wl;
    logic [5:0] stop16;
    logic [8:0] frame16;
    logic [11:0] div16, bcnt_ff, nxt_bcnt;
    logic rcp_q_ff, rcp_out_ff, rcp_oe_ff, int_tick, ext_tick, tx_tick, rx_tick;
    assign en = cmd_ff[`ASB_CMD_EN];
    assign echo = cmd_ff[`ASB_CMD_ECHO];
    assign par = cmd_ff[`ASB_CMD_PAR_EN];
    assign brk_sel = (cmd_ff[3:2] == `ASB_TXC_BREAK);
    assign wl = 4'h8 - {2'b00, ctrl_ff[6:5]};
    always_comb
    begin
        stop16 = 6'(`ASB_OVS);
        if (ctrl_ff[`ASB_CTRL_STOP])
        begin
            if (wl == 4'h5 && !par)
                stop16 = 6'(`ASB_OVS + `ASB_HALF_BIT);
            else if (!(wl == 4'h8 && par))
                stop16 = 6'(2 * `ASB_OVS);
        end
        frame16 = 9'({5'h00, 4'h1 + wl + {3'h0, par}} * `ASB_OVS) + {3'h0, stop16};
        unique case (ctrl_ff[3:0])
            4'h1: div16 = 12'(`ASB_DIV_1 / `ASB_OVS);
            4'h2: div16 = 12'(`ASB_DIV_2 / `ASB_OVS);
            4'h3: div16 = 12'(`ASB_DIV_3 / `ASB_OVS);
            4'h4: div16 = 12'(`ASB_DIV_4 / `ASB_OVS);
            4'h5: div16 = 12'(`ASB_DIV_5 / `ASB_OVS);
            4'h6: div16 = 12'(`ASB_DIV_6 / `ASB_OVS);
            4'h7: div16 = 12'(`ASB_DIV_7 / `ASB_OVS);
            4'h8: div16 = 12'(`ASB_DIV_8 / `ASB_OVS);
            4'h9: div16 = 12'(`ASB_DIV_9 / `ASB_OVS);
            4'hA: div16 = 12'(`ASB_DIV_10 / `ASB_OVS);
            4'hB: div16 = 12'(`ASB_DIV_11 / `ASB_OVS);
            4'hC: div16 = 12'(`ASB_DIV_12 / `ASB_OVS);
            4'hD: div16 = 12'(`ASB_DIV_13 / `ASB_OVS);
            4'hE: div16 = 12'(`ASB_DIV_14 / `ASB_OVS);
            4'hF: div16 = 12'(`ASB_DIV_15 / `ASB_OVS);
            4'h0: div16 = 12'h001;
        endcase
        int_tick = (bcnt_ff == 12'h000);
        nxt_bcnt = int_tick ? div16 - 12'h001 : bcnt_ff - 12'h001;
        ext_tick = receive_clock_pin_i && !rcp_q_ff;
        tx_tick = (ctrl_ff[3:0] == 4'h0) ? ext_tick : int_tick;
        rx_tick = ctrl_ff[`ASB_CTRL_RXSRC] ? tx_tick : ext_tick;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bcnt_ff <= 12'h000;
            rcp_q_ff <= 1'b0;
            rcp_out_ff <= 1'b0;
            rcp_oe_ff <= 1'b0;
        end
        else
        begin
            bcnt_ff <= nxt_bcnt;
            rcp_q_ff <= receive_clock_pin_i;
            // Drives out a clock toggled on each 16x tick so other parts can slave to it
            rcp_out_ff <= rcp_out_ff ^ int_tick;
            rcp_oe_ff <= ctrl_ff[`ASB_CTRL_RXSRC] && (ctrl_ff[3:0] != 4'h0);
        end
    end
    assign receive_clock_pin_o = rcp_out_ff;
    assign receive_clock_pin_oe = rcp_oe_ff;

    // ----------------------------------------
    // Transmitter, echo and break
    // ----------------------------------------
    asb_tx_st_t tx_st_ff, nxt_tx_st;
    logic [8:0] tsh_ff, nxt_tsh, tcnt_ff, nxt_tcnt;
    logic [3:0] tph_ff, nxt_tph, tbit_ff, nxt_tbit;
    logic [7:0] hold_ff, nxt_hold, eline_ff, nxt_eline;
    logic hold_full_ff, nxt_hold_full, txd_ff, nxt_txd, tx_ev;
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_tsh = tsh_ff;
        nxt_tcnt = tcnt_ff;
        nxt_tph = tph_ff;
        nxt_tbit = tbit_ff;
        nxt_hold = hold_ff;
        nxt_hold_full = hold_full_ff;
        nxt_txd = txd_ff;
        tx_ev = 1'b0;
        nxt_eline = rx_tick ? {eline_ff[6:0], rxd} : eline_ff;
        if (dat_wr)
        begin
            nxt_hold = wd_ff;
            nxt_hold_full = 1'b1;
        end
        unique case (tx_st_ff)
            TX_IDLE:
                if (brk_sel && !hold_full_ff)
                begin
                    nxt_tx_st = TX_BRK;
                    nxt_tcnt = frame16 - 9'h001;
                    nxt_txd = 1'b0;
                end
                else if (hold_full_ff && !cts_n && !echo)
                begin
                    nxt_tx_st = TX_SHIFT;
                    nxt_tsh = {1'b0, hold_ff} & ~(9'h1FF << wl);
                    nxt_tsh[wl] = par & (^nxt_tsh[7:0] ^ cmd_ff[`ASB_CMD_PAR_ODD]);
                    nxt_tbit = 4'h1 + wl + {3'h0, par};
                    nxt_tph = 4'hF;
                    nxt_txd = 1'b0;
                    nxt_hold_full = dat_wr;
                    tx_ev = 1'b1;
                end
            TX_SHIFT:
                if (tx_tick)
                begin
                    nxt_tph = tph_ff - 4'h1;
                    if (tph_ff == 4'h0)
                    begin
                        nxt_tbit = tbit_ff - 4'h1;
                        nxt_txd = (tbit_ff == 4'h1) ? 1'b1 : tsh_ff[0];
                        nxt_tsh = {1'b0, tsh_ff[8:1]};
                        if (tbit_ff == 4'h1)
                        begin
                            nxt_tx_st = TX_MARK;
                            nxt_tcnt = {3'h0, stop16} - 9'h001;
                        end
                    end
                end
            TX_BRK:
                if (tx_tick)
                begin
                    nxt_tcnt = tcnt_ff - 9'h001;
                    if (tcnt_ff == 9'h000)
                    begin
                        if (brk_sel)
                            nxt_tcnt = frame16 - 9'h001;
                        else
                        begin
                            nxt_tx_st = TX_MARK;
                            nxt_tcnt = 9'(`ASB_OVS - 1);
                            nxt_txd = 1'b1;
                        end
                    end
                end
            TX_MARK:
                if (tx_tick)
                begin
                    nxt_tcnt = tcnt_ff - 9'h001;
                    if (tcnt_ff == 9'h000)
                        nxt_tx_st = TX_IDLE;
                end
        endcase
        if (echo && tx_st_ff == TX_IDLE)
            nxt_txd = cts_n | eline_ff[`ASB_HALF_BIT - 1];
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_st_ff <= TX_IDLE;
            tsh_ff <= 9'h000;
            tcnt_ff <= 9'h000;
            tph_ff <= 4'h0;
            tbit_ff <= 4'h0;
            hold_ff <= 8'h00;
            hold_full_ff <= 1'b0;
            txd_ff <= 1'b1;
            eline_ff <= 8'hFF;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            tsh_ff <= nxt_tsh;
            tcnt_ff <= nxt_tcnt;
            tph_ff <= nxt_tph;
            tbit_ff <= nxt_tbit;
            hold_ff <= nxt_hold;
            hold_full_ff <= nxt_hold_full;
            txd_ff <= nxt_txd;
            eline_ff <= nxt_eline;
        end
    end
    assign txd = txd_ff;

    // ----------------------------------------
    // Receiver, independent of clear-to-send
    // ----------------------------------------
    asb_rx_st_t rx_st_ff, nxt_rx_st;
    logic [4:0] rph_ff, nxt_rph;
    logic [3:0] rbit_ff, nxt_rbit;
    logic [8:0] rsh_ff, nxt_rsh, rval;
    logic rfull_ff, nxt_rfull, pe_ff, nxt_pe, fe_ff, nxt_fe, ov_ff, nxt_ov, rx_ev;
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rph = rph_ff;
        nxt_rbit = rbit_ff;
        nxt_rsh = rsh_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rfull = rfull_ff & ~dat_rd;
        nxt_ov = ov_ff & ~dat_rd;
        nxt_pe = pe_ff;
        nxt_fe = fe_ff;
        rx_ev = 1'b0;
        rval = rsh_ff >> (4'h9 - wl - {3'h0, par});
        if (rx_tick)
        begin
            unique case (rx_st_ff)
                RX_IDLE:
                    if (!rxd)
                    begin
                        nxt_rx_st = RX_DATA;
                        nxt_rph = 5'(`ASB_OVS + `ASB_HALF_BIT - 1);
                        nxt_rbit = wl + {3'h0, par};
                    end
                RX_DATA:
                begin
                    nxt_rph = rph_ff - 5'h01;
                    if (rph_ff == 5'h00)
                    begin
                        nxt_rsh = {rxd, rsh_ff[8:1]};
                        nxt_rbit = rbit_ff - 4'h1;
                        nxt_rph = 5'(`ASB_OVS - 1);
                        if (rbit_ff == 4'h1)
                        begin
                            nxt_rx_st = RX_STOP;
                            if (stop16 == 6'(`ASB_OVS + `ASB_HALF_BIT))
                                nxt_rph = 5'(`ASB_OVS + `ASB_HALF_BIT + 4 - 1);
                        end
                    end
                end
                RX_STOP:
                begin
                    nxt_rph = rph_ff - 5'h01;
                    if (rph_ff == 5'h00)
                    begin
                        nxt_rx_st = RX_IDLE;
                        rx_ev = 1'b1;
                        if (rfull_ff && !dat_rd)
                            nxt_ov = 1'b1;
                        else
                        begin
                            nxt_rfull = 1'b1;
                            nxt_rx_data = rval[7:0] & ~(8'hFF << wl);
                            nxt_fe = !rxd;
                            nxt_pe = par & (^nxt_rx_data ^ rval[wl] ^ cmd_ff[`ASB_CMD_PAR_ODD]);
                        end
                    end
                end
                default: nxt_rx_st = RX_IDLE;
            endcase
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_st_ff <= RX_IDLE;
            rph_ff <= 5'h00;
            rbit_ff <= 4'h0;
            rsh_ff <= 9'h000;
            rx_data_ff <= 8'h00;
            rfull_ff <= 1'b0;
            ov_ff <= 1'b0;
            pe_ff <= 1'b0;
            fe_ff <= 1'b0;
        end
        else
        begin
            rx_st_ff <= nxt_rx_st;
            rph_ff <= nxt_rph;
            rbit_ff <= nxt_rbit;
            rsh_ff <= nxt_rsh;
            rx_data_ff <= nxt_rx_data;
            rfull_ff <= nxt_rfull;
            ov_ff <= nxt_ov;
            pe_ff <= nxt_pe;
            fe_ff <= nxt_fe;
        end
    end

    // ----------------------------------------
    // Modem inputs and interrupt
    // ----------------------------------------
    logic dcd_s_ff, dsr_s_ff, lock_ff, irq_ff, nxt_dcd_s, nxt_dsr_s, nxt_lock, nxt_irq, m_ev;
    always_comb
    begin
        nxt_dcd_s = dcd_s_ff;
        nxt_dsr_s = dsr_s_ff;
        nxt_lock = lock_ff & ~st_rd;
        m_ev = 1'b0;
        if (!en)
        begin
            nxt_dcd_s = dcd;
            nxt_dsr_s = dsr;
            nxt_lock = 1'b0;
        end
        else if (!lock_ff && (dcd != dcd_s_ff || dsr != dsr_s_ff))
        begin
            nxt_dcd_s = dcd;
            nxt_dsr_s = dsr;
            nxt_lock = 1'b1;
            m_ev = 1'b1;
        end
        // A new cause in the reading cycle keeps the bit set
        nxt_irq = (irq_ff & ~st_rd) | (en & (m_ev | (rx_ev & ~cmd_ff[`ASB_CMD_RXIRQ_OFF])
            | (tx_ev & (cmd_ff[3:2] == `ASB_TXC_IRQ))));
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dcd_s_ff <= 1'b0;
            dsr_s_ff <= 1'b0;
            lock_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            dcd_s_ff <= nxt_dcd_s;
            dsr_s_ff <= nxt_dsr_s;
            lock_ff <= nxt_lock;
            irq_ff <= nxt_irq;
        end
    end
    assign irq = irq_ff;
    assign status = {irq_ff, dsr_s_ff, dcd_s_ff, ~hold_full_ff, rfull_ff, ov_ff, fe_ff, pe_ff};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read_diff;
        st_rd ##1 (en && !lock_ff && dcd != dcd_s_ff);
    endsequence
    echo_path_a: assert property ((echo && !cts_n && tx_st_ff == TX_IDLE) |=>
        txd_ff == $past(eline_ff[`ASB_HALF_BIT - 1])) else $error("echo path wrong");
    echo_halt_a: assert property ((echo && cts_n && tx_st_ff == TX_IDLE) |=> txd_ff)
        else $error("echo not halted");
    dcd_irq_a: assert property ((en && !lock_ff && dcd != dcd_s_ff) |=>
        (irq_ff && lock_ff && dcd_s_ff == $past(dcd))) else $error("carrier change missed");
    dcd_hold_a: assert property ((en && lock_ff && !st_rd) |=> $stable(dcd_s_ff))
        else $error("latched carrier changed");
    reread_irq_a: assert property (s_read_diff |=> irq_ff)
        else $error("no reinterrupt after read");
    half_stop_a: assert property ((stop16 == 6'(`ASB_OVS + `ASB_HALF_BIT)) |->
        (wl == 4'h5 && !par)) else $error("half stop misapplied");
    brk_char_a: assert property ((tx_st_ff == TX_BRK) |=>
        (tx_st_ff == TX_BRK && !txd_ff) || tx_st_ff == TX_MARK) else $error("break cut");
    disabled_follow_a: assert property (!en |=> (dcd_s_ff == $past(dcd) && !lock_ff))
        else $error("status not following pins");
    irq_clear_a: assert property ((st_rd && !m_ev && !rx_ev && !tx_ev) |=> !irq_ff)
        else $error("interrupt not cleared");
    bypass_a: assert property ((ctrl_ff[3:0] == 4'h0) |-> (tx_tick == ext_tick))
        else $error("divider not bypassed");
endmodule : asb_top
